// file: src/rpms_pkg.sv
// Functional notes
// - Merge pin, watchdog, power-on, brown-out, software resets
// - Hold reset until pin, oscillator, flash ready
// - Start RC oscillator first, allow start-up
// - Power flash, wait, then start its initialisation
// - Release reset with boot block at zero
// - RC oscillator is clock source leaving reset
// - Brown-out below level raises interrupt request
// - Brown-out pending readable even when unused
// - Four brown-out levels; selected one forces reset
// - Active after reset with default gating values
// - Each analog block switchable through run config
// - System clock source: RC, system or watchdog
// - Per-peripheral divider; zero stops that clock
// - Sleep gates core clock until interrupt/reset
// - Sleep keeps enabled peripherals and state running
// - Sleep interrupt wake keeps config; deep-sleep wake loads wake config; non-power-on reset restores defaults except brown-out control
// - Deep-sleep: all analog off except selected two
// - Deep-sleep: only watchdog oscillator may run
// - Run config writes act at once
// - RC power-down waits for clean clock stop

package rpms_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_MHZ      = 40;          // pclk rate
	localparam int          IRC_START_US = 6;           // Oscillator start-up, longest
	localparam int          FLASH_PWR_US = 100;         // Flash power-up, least
	localparam logic [11:0] IRC_CYC      = 12'(IRC_START_US * CLK_MHZ);
	localparam logic [11:0] FLASH_CYC    = 12'(FLASH_PWR_US * CLK_MHZ);

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] ADR_RUNPD  = 12'h000;   // run_power_down_config
	localparam logic [11:0] ADR_SLPPD  = 12'h004;   // sleep_power_down_config
	localparam logic [11:0] ADR_WAKPD  = 12'h008;   // wake_power_down_config
	localparam logic [11:0] ADR_BUSCLK = 12'h00c;   // bus_clock_enable_control
	localparam logic [11:0] ADR_MSEL   = 12'h010;   // main_clock_source_select
	localparam logic [11:0] ADR_SDIV   = 12'h014;   // system_clock_divider
	localparam logic [11:0] ADR_POWER_CONTROL_REGISTER   = 12'h018;   // power_control_register
	localparam logic [11:0] ADR_BODC   = 12'h01c;   // Brown-out control
	localparam logic [11:0] ADR_CAUSE  = 12'h020;   // Reset cause, write 1 clears
	localparam logic [11:0] ADR_STAT   = 12'h024;   // Live status, read only
	localparam logic [11:0] ADR_PDIV0  = 12'h028;   // First peripheral divider

	// ****************************************
	// Reset values and fields
	// ****************************************
	localparam logic [15:0] RUN_PD_RST  = 16'hedf0;     // Run config default
	localparam logic [15:0] SLP_PD_RST  = 16'hffff;     // Sleep config default
	localparam logic [15:0] WAK_PD_RST  = 16'hedf0;     // Wake config default
	localparam logic [31:0] BUS_CLK_RST = 32'h0000_001f; // Bus clock enables
	localparam int          PD_IRCOUT   = 0;            // RC output power-down
	localparam int          PD_IRC      = 1;            // RC power-down
	localparam int          PD_FLASH    = 2;            // Flash power-down
	localparam int          PD_BOD      = 3;            // Brown-out power-down
	localparam int          PD_WDTOSC   = 6;            // Watchdog osc power-down
	localparam int          PC_DPD      = 1;            // deep_powerdown_select_bit
	localparam int          PC_BOOT     = 2;            // Boot block mapped at 0
	localparam int          CS_POR      = 0;            // Cause: power-on
	localparam int          CS_EXT      = 1;            // Cause: pin
	localparam int          CS_WDT      = 2;            // Cause: watchdog
	localparam int          CS_BOD      = 3;            // Cause: brown-out
	localparam int          CS_SW       = 4;            // Cause: software
	localparam logic [1:0]  CLK_IRC     = 2'h0;         // Main clock: RC osc
	localparam logic [1:0]  CLK_SYSOSC  = 2'h1;         // Main clock: system osc
	localparam logic [1:0]  CLK_WDTOSC  = 2'h2;         // Main clock: watchdog osc

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [2:0] {
		RS_HOLD  = 3'b000,  // A source is active
		RS_IRC   = 3'b001,  // Oscillator start-up
		RS_FPWR  = 3'b010,  // Flash power-up wait
		RS_FINIT = 3'b011,  // Flash initialising
		RS_RUN   = 3'b100   // Reset released
	} rpms_rst_t;

	typedef enum logic [1:0] {
		MD_ACTIVE = 2'b00,  // Core clocked
		MD_SLEEP  = 2'b01,  // Core gated
		MD_DEEP   = 2'b10   // Core gated, analog off
	} rpms_mode_t;

endpackage

// file: src/rpms_sequencer.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rpms_sequencer import rpms_pkg::*; #(
	parameter int NPD = 3                       // Peripheral dividers
) (
	input  wire logic            pclk,          // 40 MHz clock
	input  wire logic            presetn,       // Power-on reset, low
	input  wire logic            psel,          // APB select
	input  wire logic            penable,       // APB enable
	input  wire logic            pwrite,        // APB direction
	input  wire logic [11:0]     paddr,         // APB byte address
	input  wire logic [31:0]     pwdata,        // APB write data
	output logic      [31:0]     prdata,        // APB read data
	output logic                 pready,        // APB ready
	output logic                 pslverr,       // APB unmapped access
	input  wire logic            ext_reset_n,   // Reset pin, low
	input  wire logic            wdt_reset,     // Watchdog reset level
	input  wire logic            irc_ok,        // RC oscillator running
	input  wire logic [3:0]      bod_below,     // Supply below each level
	input  wire logic            sw_reset_req,  // Core software reset pulse
	input  wire logic            flash_init_done, // Flash ready level
	input  wire logic            core_wfi,      // Wait-for-interrupt pulse
	input  wire logic            core_deep,     // deep_sleep_select_bit
	input  wire logic            irq_wake,      // Enabled interrupt pending
	output logic                 chip_reset_n_q, // Internal reset, low
	output logic                 flash_init_start_q, // Flash init pulse
	output logic      [15:0]     analog_pd_q,   // Analog power-downs
	output logic                 irc_clk_en_q,  // RC clock gate
	output logic                 core_clk_en_q, // Core clock gate
	output logic                 sys_clk_run_q, // System clock allowed
	output logic      [1:0]      main_clk_sel_q, // Main clock source
	output logic      [7:0]      sys_clk_div_q, // System clock divider
	output logic      [31:0]     bus_clk_en_q,  // Bus clock enables
	output logic      [NPD-1:0]  pclk_en_q,     // Peripheral clock ticks
	output logic                 bod_irq_q,     // Brown-out interrupt
	output logic                 boot_map_q,    // Boot block at zero
	output logic      [1:0]      power_mode_q   // Current mode
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		rpms_rst_t               st;        // Reset sequence
		rpms_mode_t              md;        // Power mode
		logic [11:0]             cnt;       // Sequence timer
		logic                    ext_m;     // Pin sync stage 1
		logic                    ext_s;     // Pin sync stage 2
		logic                    wdt_m;     // Watchdog sync 1
		logic                    wdt_s;     // Watchdog sync 2
		logic                    irc_m;     // Oscillator sync 1
		logic                    irc_s;     // Oscillator sync 2
		logic [3:0]              bod_m;     // Brown-out sync 1
		logic [3:0]              bod_s;     // Brown-out sync 2
		logic [15:0]             run;       // Run config
		logic [15:0]             slp;       // Sleep config
		logic [15:0]             wak;       // Wake config
		logic [31:0]             bus;       // Bus clock enables
		logic [1:0]              msel;      // Main clock select
		logic [7:0]              sdiv;      // System divider
		logic                    dp_sel;    // Deep power-down select
		logic [4:0]              bodc;      // Brown-out control
		logic [4:0]              cause;     // Sticky reset causes
		logic [NPD-1:0][7:0]     pdiv;      // Peripheral dividers
		logic [NPD-1:0][7:0]     pcnt;      // Divider counters
		logic [NPD-1:0]          pclk_en;   // Divider ticks
		logic                    rdy;       // APB ready
		logic [31:0]             rdata;     // APB read data
		logic                    err;       // APB error
		logic                    chip_rst_n; // Internal reset
		logic                    fl_start;  // Flash start pulse
		logic                    irc_en;    // RC clock gate
		logic [15:0]             apd;       // Analog power-downs
		logic                    core_en;   // Core clock gate
		logic                    sys_run;   // System clock allowed
		logic                    bod_irq;   // Brown-out interrupt
		logic                    boot_map;  // Boot block mapped
	} rpms_st_t;

	localparam rpms_st_t R0 = '{
		st: RS_HOLD, md: MD_ACTIVE, run: RUN_PD_RST, slp: SLP_PD_RST,
		wak: WAK_PD_RST, bus: BUS_CLK_RST, cause: 5'h01, apd: RUN_PD_RST,
		irc_en: 1'b1, core_en: 1'b0, sys_run: 1'b1, boot_map: 1'b1,
		ext_m: 1'b1, ext_s: 1'b1, default: '0 // Pin sync idles released, no false cause
	};

	rpms_st_t    r;         // Registered state
	rpms_st_t    n;         // Next state
	logic        acc;       // Access phase
	logic        wr;        // Write takes effect
	logic        hit;       // Address mapped
	logic [31:0] rd;        // Read mux
	logic        bod_rst;   // Brown-out reset request
	logic        src;       // Any reset source
	logic [15:0] pd_req;    // Requested power-downs

	// Brown-out comparator at a chosen level
	function automatic logic bod_pick(input logic [3:0] lv, input logic [1:0] sel);
		return lv[sel];
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	// All decisions in one place so the struct stays self-consistent
	always_comb begin
		n = r;
		// Asynchronous inputs pass two flops before use
		n.ext_m = ext_reset_n;
		n.ext_s = r.ext_m;
		n.wdt_m = wdt_reset;
		n.wdt_s = r.wdt_m;
		n.irc_m = irc_ok;
		n.irc_s = r.irc_m;
		n.bod_m = bod_below;
		n.bod_s = r.bod_m;
		n.fl_start = 1'b0;

		// APB: one wait state, answer registered
		acc = psel && penable;
		wr = acc && r.rdy && pwrite;
		hit = 1'b1;
		rd = '0;
		case (paddr)
			ADR_RUNPD:  rd = {16'h0000, r.run};
			ADR_SLPPD:  rd = {16'h0000, r.slp};
			ADR_WAKPD:  rd = {16'h0000, r.wak};
			ADR_BUSCLK: rd = r.bus;
			ADR_MSEL:   rd = {30'h0, r.msel};
			ADR_SDIV:   rd = {24'h0, r.sdiv};
			ADR_POWER_CONTROL_REGISTER:   rd = {29'h0, r.boot_map, r.dp_sel, 1'b0};
			ADR_BODC:   rd = {27'h0, r.bodc};
			ADR_CAUSE:  rd = {27'h0, r.cause};
			// Pending brown-out stays visible here
			ADR_STAT:   rd = {20'h0, r.bod_s, 1'b0, r.bod_irq, r.md, r.st, r.irc_en};
			default:    hit = 1'b0;
		endcase
		for (int i = 0; i < NPD; i++) begin
			if (paddr == ADR_PDIV0 + 12'(4 * i)) begin
				hit = 1'b1;
				rd = {24'h0, r.pdiv[i]};
			end
		end
		n.rdy = acc && !r.rdy;
		n.rdata = (acc && !r.rdy && !pwrite && hit) ? rd : 32'h0;
		n.err = acc && !r.rdy && !hit;

		// Register writes land on the edge that samples pready
		if (wr) begin
			case (paddr)
				ADR_RUNPD:  n.run = pwdata[15:0];
				ADR_SLPPD:  n.slp = pwdata[15:0];
				ADR_WAKPD:  n.wak = pwdata[15:0];
				ADR_BUSCLK: n.bus = pwdata;
				ADR_MSEL:   n.msel = pwdata[1:0];
				ADR_SDIV:   n.sdiv = pwdata[7:0];
				ADR_POWER_CONTROL_REGISTER: begin
					n.dp_sel = pwdata[PC_DPD];
					n.boot_map = pwdata[PC_BOOT];
				end
				ADR_BODC:   n.bodc = pwdata[4:0];
				ADR_CAUSE:  n.cause = r.cause & ~pwdata[4:0];
				default:    ;
			endcase
			for (int i = 0; i < NPD; i++) begin
				if (paddr == ADR_PDIV0 + 12'(4 * i)) begin
					n.pdiv[i] = pwdata[7:0];
				end
			end
		end

		// Brown-out reset at the selected level, if enabled and powered
		bod_rst = bod_pick(r.bod_s, r.bodc[1:0]) && r.bodc[4]
			&& !r.apd[PD_BOD];
		src = !r.ext_s || r.wdt_s || bod_rst || sw_reset_req;

		// Sequencer
		if (src) begin
			// Causes set after the clear, so a new one is never lost
			n.cause[CS_EXT] = n.cause[CS_EXT] || !r.ext_s;
			n.cause[CS_WDT] = n.cause[CS_WDT] || r.wdt_s;
			n.cause[CS_BOD] = n.cause[CS_BOD] || bod_rst;
			n.cause[CS_SW] = n.cause[CS_SW] || sw_reset_req;
			n.st = RS_HOLD;
			n.md = MD_ACTIVE;
			n.cnt = '0;
			// A pin, watchdog, brown-out or software reset restores the default configuration, except brown-out control (bodc)
			n.run = RUN_PD_RST;
			n.slp = SLP_PD_RST;
			n.wak = WAK_PD_RST;
			n.bus = BUS_CLK_RST;
			n.msel = CLK_IRC;
			n.sdiv = '0;
			n.dp_sel = 1'b0;
			n.pdiv = '0;
			n.boot_map = 1'b1;
		end else begin
			unique case (r.st)
				RS_HOLD: begin
					n.st = RS_IRC;
					n.cnt = '0;
				end
				RS_IRC: begin
					// Clock trusted after start-up time and running flag
					if (r.cnt == IRC_CYC - 12'h001 && r.irc_s) begin
						n.st = RS_FPWR;
						n.cnt = '0;
					end else if (r.cnt != IRC_CYC - 12'h001) begin
						n.cnt = r.cnt + 12'h001;
					end
				end
				RS_FPWR: begin
					// Flash powered, wait, then launch init
					if (r.cnt == FLASH_CYC - 12'h001) begin
						n.st = RS_FINIT;
						n.fl_start = 1'b1;
					end else begin
						n.cnt = r.cnt + 12'h001;
					end
				end
				RS_FINIT: begin
					if (flash_init_done) begin
						n.st = RS_RUN;
					end
				end
				RS_RUN: begin
					unique case (r.md)
						MD_ACTIVE: begin
							// Entry needs dp_sel clear; core_deep picks deep-sleep or sleep
							if (core_wfi && !r.dp_sel) begin
								n.md = core_deep ? MD_DEEP : MD_SLEEP;
							end
						end
						MD_SLEEP: begin
							// Config untouched on interrupt wake
							if (irq_wake) begin
								n.md = MD_ACTIVE;
							end
						end
						MD_DEEP: begin
							if (irq_wake) begin
								n.md = MD_ACTIVE;
								n.run = r.wak;
							end
						end
						default: n.md = MD_ACTIVE;
					endcase
				end
				default: n.st = RS_HOLD;
			endcase
		end

		// Peripheral dividers; zero stops the clock
		for (int i = 0; i < NPD; i++) begin
			n.pclk_en[i] = 1'b0;
			if (n.pdiv[i] == 8'h00) begin
				n.pcnt[i] = '0;
			end else if (r.pcnt[i] >= n.pdiv[i] - 8'h01) begin
				n.pcnt[i] = '0;
				n.pclk_en[i] = 1'b1;
			end else begin
				n.pcnt[i] = r.pcnt[i] + 8'h01;
			end
		end

		// Power-down request, from the next config so writes act at once
		pd_req = n.run;
		if (n.st != RS_RUN) begin
			pd_req = RUN_PD_RST;                // RC runs from the start
			pd_req[PD_FLASH] = (n.st == RS_HOLD) || (n.st == RS_IRC);
		end else if (n.md == MD_DEEP) begin
			// Only brown-out and watchdog osc may stay on
			pd_req = 16'hffff;
			pd_req[PD_BOD] = n.slp[PD_BOD];
			pd_req[PD_WDTOSC] = n.slp[PD_WDTOSC];
		end
		// RC clock stops a cycle before its power goes, no runt pulse
		n.irc_en = !pd_req[PD_IRC] && !pd_req[PD_IRCOUT];
		n.apd = pd_req;
		n.apd[PD_IRC] = pd_req[PD_IRC] && !r.irc_en;
		n.apd[PD_IRCOUT] = pd_req[PD_IRCOUT] && !r.irc_en;

		n.chip_rst_n = (n.st == RS_RUN);
		n.core_en = (n.st == RS_RUN) && (n.md == MD_ACTIVE);
		// Bus clocks stay as set in sleep
		n.sys_run = (n.md != MD_DEEP) || (n.msel == CLK_WDTOSC);
		n.bod_irq = bod_pick(r.bod_s, r.bodc[3:2]) && !r.apd[PD_BOD];
	end

	// ****************************************
	// Registers
	// ****************************************
	// Reset asserts at once; release only ever comes through the FSM
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= R0;
		end else begin
			r <= n;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata             = r.rdata;
	assign pready             = r.rdy;
	assign pslverr            = r.err;
	assign chip_reset_n_q     = r.chip_rst_n;
	assign flash_init_start_q = r.fl_start;
	assign analog_pd_q        = r.apd;
	assign irc_clk_en_q       = r.irc_en;
	assign core_clk_en_q      = r.core_en;
	assign sys_clk_run_q      = r.sys_run;
	assign main_clk_sel_q     = r.msel;
	assign sys_clk_div_q      = r.sdiv;
	assign bus_clk_en_q       = r.bus;
	assign pclk_en_q          = r.pclk_en;
	assign bod_irq_q          = r.bod_irq;
	assign boot_map_q         = r.boot_map;
	assign power_mode_q       = r.md;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence irc_done_s;
		r.st == RS_IRC ##1 r.st == RS_FPWR;
	endsequence
	sequence fpwr_done_s;
		r.st == RS_FPWR ##1 r.st == RS_FINIT;
	endsequence
	pin_holds_reset_a: assert property (
		!r.ext_s |=> !chip_reset_n_q)
		else $error("reset released while pin held");
	irc_startup_a: assert property (
		irc_done_s |-> $past(r.cnt) == IRC_CYC - 12'h001)
		else $error("oscillator wait wrong length");
	flash_power_a: assert property (
		fpwr_done_s |-> $past(r.cnt) == FLASH_CYC - 12'h001 && flash_init_start_q
			##1 !flash_init_start_q)
		else $error("flash power wait or start pulse wrong");
	release_defaults_a: assert property (
		$rose(chip_reset_n_q) |-> $past(flash_init_done) && main_clk_sel_q == CLK_IRC
			&& boot_map_q && power_mode_q == MD_ACTIVE)
		else $error("reset released without defaults");
	bod_irq_a: assert property (
		bod_pick(r.bod_s, r.bodc[3:2]) && !r.apd[PD_BOD] |=> bod_irq_q)
		else $error("brown-out interrupt missing");
	sleep_gate_a: assert property (
		r.md == MD_SLEEP |-> !core_clk_en_q && sys_clk_run_q)
		else $error("core clock running in sleep");
	sleep_keeps_a: assert property (
		$past(r.md) == MD_SLEEP && r.md == MD_ACTIVE && chip_reset_n_q
			|-> r.run == $past(r.run))
		else $error("sleep wake changed run config");
	deep_power_a: assert property (
		r.md == MD_DEEP |-> analog_pd_q[PD_FLASH] && analog_pd_q[4]
			&& analog_pd_q[5] && analog_pd_q[7])
		else $error("analog block on in deep-sleep");
	irc_clean_a: assert property (
		$rose(analog_pd_q[PD_IRC]) |-> !irc_clk_en_q && $past(!irc_clk_en_q))
		else $error("oscillator powered down while clocked");
endmodule

`default_nettype wire

// file: tb/rpms_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Processor core stand-in
// ****************************************
module rpms_core_model (
	input  wire logic pclk,         // Core clock
	output logic      core_wfi,     // Wait-for-interrupt pulse
	output logic      core_deep,    // deep_sleep_select_bit
	output logic      irq_wake,     // Enabled interrupt pending
	output logic      sw_reset_req  // Software reset pulse
);
	// Idle core: no request and nothing pending
	initial begin
		core_wfi     = 1'b0;
		core_deep    = 1'b0;
		irq_wake     = 1'b0;
		sw_reset_req = 1'b0;
	end

	// Select bit settles a cycle ahead, so the wait never sees a stale mode
	task automatic sleep(input logic deep);
		@(posedge pclk);
		core_deep <= deep;
		@(posedge pclk);
		core_wfi  <= 1'b1;
		@(posedge pclk);
		core_wfi  <= 1'b0;
	endtask

	// One-cycle interrupt, the shortest a wake source can be
	task automatic pulse_irq;
		@(posedge pclk);
		irq_wake <= 1'b1;
		@(posedge pclk);
		irq_wake <= 1'b0;
	endtask

	// Software reset request
	task automatic soft_reset;
		@(posedge pclk);
		sw_reset_req <= 1'b1;
		@(posedge pclk);
		sw_reset_req <= 1'b0;
	endtask
endmodule

`default_nettype wire

// file: tb/rpms_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rpms_sequencer_tb import rpms_pkg::*;;
	// ****************************************
	// Signals
	// ****************************************
	logic        pclk, presetn, psel, penable, pwrite;       // Clock, reset, APB
	logic [11:0] paddr;                                      // APB address
	logic [31:0] pwdata, prdata, rdat;                       // APB data
	logic        pready, pslverr, rerr;                      // APB answer
	logic        ext_reset_n, wdt_reset, irc_ok, flash_init_done; // Sources
	logic [3:0]  bod_below;                                  // Supply levels
	logic        core_wfi, core_deep, irq_wake, sw_reset_req; // From core
	logic        chip_reset_n_q, flash_init_start_q, irc_clk_en_q; // Reset side
	logic        core_clk_en_q, sys_clk_run_q, bod_irq_q, boot_map_q; // Status
	logic [15:0] analog_pd_q;                                // Power-downs
	logic [1:0]  main_clk_sel_q, power_mode_q;               // Clock and mode
	logic [7:0]  sys_clk_div_q;                              // Divider copy
	logic [31:0] bus_clk_en_q;                               // Bus enables
	logic [2:0]  pclk_en_q;                                  // Divider ticks
	int          bad_count, check_count, cyc;                // Counters

	rpms_sequencer #(.NPD(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
		.wdt_reset(wdt_reset), .irc_ok(irc_ok), .bod_below(bod_below),
		.sw_reset_req(sw_reset_req), .flash_init_done(flash_init_done),
		.core_wfi(core_wfi), .core_deep(core_deep), .irq_wake(irq_wake),
		.chip_reset_n_q(chip_reset_n_q), .flash_init_start_q(flash_init_start_q),
		.analog_pd_q(analog_pd_q), .irc_clk_en_q(irc_clk_en_q),
		.core_clk_en_q(core_clk_en_q), .sys_clk_run_q(sys_clk_run_q),
		.main_clk_sel_q(main_clk_sel_q), .sys_clk_div_q(sys_clk_div_q),
		.bus_clk_en_q(bus_clk_en_q), .pclk_en_q(pclk_en_q), .bod_irq_q(bod_irq_q),
		.boot_map_q(boot_map_q), .power_mode_q(power_mode_q));

	rpms_core_model core_u (.pclk(pclk), .core_wfi(core_wfi), .core_deep(core_deep),
		.irq_wake(irq_wake), .sw_reset_req(sw_reset_req));

	// ****************************************
	// Clock, timeout and shared tasks
	// ****************************************
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	// Five boot sequences of about 4300 cycles fit well inside this ceiling
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Request held until pready is seen high at a rising edge; answer taken there.
	// A lost answer is ended only by the cycle ceiling
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
		@(negedge pclk);
	endtask

	task automatic wait_mode(input logic [1:0] m);
		for (int n = 0; n < 8 && power_mode_q !== m; n++) @(negedge pclk);
	endtask

	// Boot from a released source; flash power-up time is counted from when the flash power-down clears
	task automatic boot;
		int n;
		n = 0;
		while (analog_pd_q[PD_FLASH] !== 1'b0) @(negedge pclk);
		while (flash_init_start_q !== 1'b1) begin
			@(negedge pclk);
			n++;
		end
		chk(n, FLASH_CYC);
		chk(analog_pd_q[PD_FLASH], 1'b0);
		chk(chip_reset_n_q, 1'b0);
		@(posedge pclk);
		flash_init_done <= 1'b1;
		for (n = 0; n < 4 && chip_reset_n_q !== 1'b1; n++) @(negedge pclk);
		chk(chip_reset_n_q, 1'b1);
		chk(boot_map_q, 1'b1);
		chk(main_clk_sel_q, CLK_IRC);
		chk(analog_pd_q, RUN_PD_RST);
		chk(bus_clk_en_q, BUS_CLK_RST);
		chk(sys_clk_div_q, 8'h00);
		chk(power_mode_q, MD_ACTIVE);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		int t;
		apb(1'b1, 12'hffc, 32'h0);
		chk(rerr, 1'b1);
		chk(analog_pd_q, RUN_PD_RST);
		apb(1'b1, ADR_RUNPD, 32'h0000_ed60);
		chk(analog_pd_q, 16'hed60);
		apb(1'b1, ADR_MSEL, 32'h2);
		chk(main_clk_sel_q, CLK_WDTOSC);
		apb(1'b1, ADR_SDIV, 32'h3);
		chk(sys_clk_div_q, 8'h03);
		apb(1'b1, ADR_PDIV0, 32'h2);
		t = 0;
		repeat (8) begin
			@(negedge pclk);
			t += pclk_en_q[0];
		end
		chk(t, 4);
		apb(1'b1, ADR_PDIV0, 32'h0);
		repeat (8) begin
			@(negedge pclk);
			t += pclk_en_q[0];
		end
		chk(t, 4);
	endtask

	task automatic t_sleep;
		core_u.sleep(1'b0);
		wait_mode(MD_SLEEP);
		chk(power_mode_q, MD_SLEEP);
		chk({core_clk_en_q, sys_clk_run_q}, 2'b01);
		chk(analog_pd_q, 16'hed60);
		core_u.pulse_irq();
		wait_mode(MD_ACTIVE);
		chk(core_clk_en_q, 1'b1);
		chk(analog_pd_q, 16'hed60);
		chk(main_clk_sel_q, CLK_WDTOSC);
		chk(sys_clk_div_q, 8'h03);
	endtask

	// Entry steps in the required order: select bits, sleep cfg, clock, wake cfg.
	// Watchdog osc stays off in deep-sleep; brown-out is the one block kept on
	task automatic t_deep;
		apb(1'b1, ADR_POWER_CONTROL_REGISTER, 32'h4);
		apb(1'b1, ADR_SLPPD, 32'h0000_fff7);
		apb(1'b1, ADR_MSEL, 32'h0);
		apb(1'b1, ADR_WAKPD, {16'h0, WAK_PD_RST});
		core_u.sleep(1'b1);
		wait_mode(MD_DEEP);
		chk(analog_pd_q[PD_IRC], 1'b0);
		repeat (2) @(negedge pclk);
		chk(analog_pd_q, 16'hfff7);
		chk({irc_clk_en_q, core_clk_en_q}, 2'b00);
		core_u.pulse_irq();
		wait_mode(MD_ACTIVE);
	endtask

	// Irq on level 1, reset on level 2 with reset enabled
	task automatic t_bod;
		apb(1'b1, ADR_BODC, 32'h16);
		@(posedge pclk);
		bod_below <= 4'b0010;
		repeat (6) @(negedge pclk);
		chk({bod_irq_q, chip_reset_n_q}, 2'b11);
		apb(1'b0, ADR_STAT, 32'h0);
		chk(rdat[6], 1'b1);
		@(posedge pclk);
		bod_below <= 4'b0110;
		flash_init_done <= 1'b0;
		repeat (6) @(negedge pclk);
		chk(chip_reset_n_q, 1'b0);
		@(posedge pclk);
		bod_below <= 4'b0000;
		boot();
	endtask

	task automatic t_sources;
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, ADR_MSEL, 32'h1);
			@(posedge pclk);
			flash_init_done <= 1'b0;
			if (k == 0) ext_reset_n <= 1'b0;
			else if (k == 1) wdt_reset <= 1'b1;
			else core_u.soft_reset();
			repeat (6) @(negedge pclk);
			chk(chip_reset_n_q, 1'b0);
			@(posedge pclk);
			{ext_reset_n, wdt_reset} <= 2'b10;
			boot();
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_reset_n, wdt_reset, irc_ok, flash_init_done, bod_below} = 8'h80;
		{bad_count, check_count, cyc} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({chip_reset_n_q, irc_clk_en_q}, 2'b01);
		// Oscillator flag held off past the start-up time: flash must stay off
		repeat (300) @(posedge pclk);
		@(negedge pclk);
		chk(analog_pd_q[PD_FLASH], 1'b1);
		@(posedge pclk);
		irc_ok <= 1'b1;
		boot();
		t_regs();
		t_sleep();
		t_deep();
		t_bod();
		t_sources();
		final_report();
	end
endmodule

`default_nettype wire
